// ==== shared/vcr_pkg.sv ====
package vcr_pkg;
    // ==========================================================
    // Register indices of the capability bank.
    localparam logic [11:0] VCR_IDX_BASIC     = 12'h480;
    localparam logic [11:0] VCR_IDX_PIN_CTL   = 12'h481;
    localparam logic [11:0] VCR_IDX_PROC_CTL  = 12'h482;
    localparam logic [11:0] VCR_IDX_EXIT_CTL  = 12'h483;
    localparam logic [11:0] VCR_IDX_ENTRY_CTL = 12'h484;
    localparam logic [11:0] VCR_IDX_MISC      = 12'h485;
    localparam logic [11:0] VCR_IDX_CR0_F1S   = 12'h486;
    localparam logic [11:0] VCR_IDX_CR0_F0S   = 12'h487;
    localparam logic [11:0] VCR_IDX_CR4_F1S   = 12'h488;
    localparam logic [11:0] VCR_IDX_CR4_F0S   = 12'h489;
    localparam logic [11:0] VCR_IDX_ENUM      = 12'h48A;

    // ==========================================================
    // Field widths and positions.
    localparam int VCR_REV_W      = 32;
    localparam int VCR_SIZE_W     = 13;
    localparam int VCR_MTYPE_W    = 4;
    localparam int VCR_CR3CNT_W   = 9;
    localparam int VCR_LISTN_W    = 3;
    localparam int VCR_ACT_W      = 3;
    localparam int VCR_IDXF_W     = 9;
    localparam int VCR_RANGE_TYPE_REGISTERS_E_BIT = 11;
    localparam int VCR_ENC_RSV_LO = 15;
    localparam int VCR_ENC_RSV12  = 12;
    localparam int VCR_ENC_IDX_LO = 1;
    localparam int VCR_ENC_IDX_HI = 9;

    // ==========================================================
    // Limits and encodings.
    localparam int          VCR_SIZE_MAX   = 4096;
    localparam int          VCR_CR3CNT_MAX = 256;
    localparam int          VCR_LIST_UNIT  = 512;
    localparam logic [3:0]  VCR_MT_UC      = 4'h0;
    localparam logic [3:0]  VCR_MT_WB      = 4'h6;
    localparam logic [1:0]  VCR_ACT_ACTIVE = 2'h0;
    localparam logic [15:0] VCR_GP_CODE    = 16'h0000;
endpackage

// ==== rtl/vcr_bank.sv ====
`timescale 1ns/1ps
// Notes on behaviour
// - Basic low word holds structure revision.
// - Bits 44:32 give region size, 1..4096.
// - Bit 48 gives structure address limit.
// - Bit 49 dual-monitor support always one.
// - Bits 53:50 give structure memory type.
// - Basic reserved bits read as zero.
// - Range types off forces uncacheable access.
// - Low word lists allowed zero settings.
// - High word lists allowed one settings.
// - Misc bits 8:6 list activity states.
// - Unsupported activity state fails entry.
// - Misc bits 24:16 give target count.
// - Misc bits 27:25 bound list lengths.
// - Misc high word holds segment revision.
// - Misc reserved bits read as zero.
// - Register zero follows fixed bits when on.
// - Fixed-bit pairs are always consistent.
// - Register four follows fixed bits when on.
// - Field encoding layout and reserved bits.
// - Enumeration reports highest field index.
// - Writes fault with error code zero.
module vcr_bank
    import vcr_pkg::*;
#(
    parameter logic [31:0] STRUCT_REV   = 32'h0000_0001,
    parameter int          REGION_SIZE  = 4096,
    parameter bit          ADDR_32      = 1'b0,
    parameter logic [3:0]  STRUCT_MTYPE = VCR_MT_WB,
    parameter logic [63:0] PIN_CAP      = 64'h0000_001F_0000_0016,
    parameter logic [63:0] PROC_CAP     = 64'hFFFF_FFFF_0401_E172,
    parameter logic [63:0] EXIT_CAP     = 64'h0003_6FFF_0003_6DFF,
    parameter logic [63:0] ENTRY_CAP    = 64'h0000_11FF_0000_11FF,
    parameter logic [2:0]  ACT_STATES   = 3'h7,
    parameter int          CR3_COUNT    = 4,
    parameter logic [2:0]  LIST_N       = 3'h0,
    parameter logic [31:0] SEG_REV      = 32'h0000_0000,
    parameter logic [63:0] CR0_FIX1S    = 64'h0000_0000_8000_0021,
    parameter logic [63:0] CR0_FIX0S    = 64'h0000_0000_FFFF_FFFF,
    parameter logic [63:0] CR4_FIX1S    = 64'h0000_0000_0000_2000,
    parameter logic [63:0] CR4_FIX0S    = 64'h0000_0000_0000_27FF,
    parameter logic [8:0]  MAX_INDEX    = 9'h01C
) (
    input  wire logic        CLK,          // Processor clock.
    input  wire logic        RST,          // Async reset, high.
    input  wire logic        RD_REQ,       // Read request pulse.
    input  wire logic        WR_REQ,       // Write attempt pulse.
    input  wire logic [11:0] REG_INDEX,    // Register index.
    output logic      [63:0] RD_DATA,      // Read data.
    output logic             RD_VALID,     // Read done pulse.
    output logic             GP_FAULT,     // Fault pulse.
    output logic      [15:0] GP_CODE,      // Fault error code.
    input  wire logic [11:0] DEF_MEM_TYPE_REG, // Default type reg.
    output logic      [3:0]  STRUCT_MEM_TYPE,  // Type in use.
    input  wire logic        ENTRY_REQ,    // Entry check pulse.
    input  wire logic [31:0] PIN_CTLS,     // Pin controls.
    input  wire logic [31:0] PROC_CTLS,    // Processor controls.
    input  wire logic [31:0] EXIT_CTLS,    // Exit controls.
    input  wire logic [31:0] ENTRY_CTLS,   // Entry controls.
    input  wire logic [1:0]  ACT_STATE,    // Requested activity.
    input  wire logic [31:0] EXIT_STORE_CNT, // List length.
    input  wire logic [31:0] EXIT_LOAD_CNT,  // List length.
    input  wire logic [31:0] ENTRY_LOAD_CNT, // List length.
    output logic             ENTRY_DONE,   // Check done pulse.
    output logic             ENTRY_FAIL,   // Entry refused.
    output logic             LIST_OVER,    // List beyond limit.
    input  wire logic        VIRT_ON,      // Operation is on.
    input  wire logic [63:0] CREG0_IN,     // Register zero wanted.
    input  wire logic [63:0] CREG4_IN,     // Register four wanted.
    output logic      [63:0] CREG0_OUT,    // Register zero held.
    output logic      [63:0] CREG4_OUT,    // Register four held.
    input  wire logic [31:0] FIELD_ENC,    // Field encoding.
    output logic             FIELD_ENC_OK  // Encoding is legal.
);

    // ==========================================================
    // Elaboration checks.
    // Refuses out-of-range sizes and target counts, unused memory types and inconsistent fixed pairs.
    if (REGION_SIZE < 1 || REGION_SIZE > VCR_SIZE_MAX) begin
        $error("Region size out of range.");
    end
    if (CR3_COUNT < 0 || CR3_COUNT > VCR_CR3CNT_MAX) begin
        $error("Target count out of range.");
    end
    if (STRUCT_MTYPE != VCR_MT_UC && STRUCT_MTYPE != VCR_MT_WB) begin
        $error("Memory type code is unused.");
    end
    if ((CR0_FIX1S & ~CR0_FIX0S) != 64'h0) begin
        $error("Register zero fixed pair inconsistent.");
    end
    if ((CR4_FIX1S & ~CR4_FIX0S) != 64'h0) begin
        $error("Register four fixed pair inconsistent.");
    end

    // ==========================================================
    // Functions.

    // True when the controls respect both allowed-setting halves.
    function automatic logic ctl_ok(input logic [31:0] ctl,
                                    input logic [63:0] cap);
        logic zero_bad;
        logic one_bad;
        zero_bad = |(~ctl & cap[31:0]);
        one_bad  = |(ctl & ~cap[63:32]);
        return !(zero_bad || one_bad);
    endfunction

    // Forces fixed-one bits high and fixed-zero bits low.
    function automatic logic [63:0] fix_bits(input logic [63:0] v,
                                             input logic [63:0] f1s,
                                             input logic [63:0] f0s);
        return (v | f1s) & f0s;
    endfunction

    // ==========================================================
    // Constant register images.
    localparam logic [VCR_SIZE_W-1:0] SIZE_F =
        VCR_SIZE_W'(REGION_SIZE);
    localparam logic [VCR_CR3CNT_W-1:0] CR3_F =
        VCR_CR3CNT_W'(CR3_COUNT);
    localparam logic [63:0] BASIC_VAL = {
        10'h000,
        STRUCT_MTYPE,
        1'b1,
        ADDR_32,
        3'h0,
        SIZE_F,
        STRUCT_REV
    };
    localparam logic [63:0] MISC_VAL = {
        SEG_REV,
        4'h0,
        LIST_N,
        CR3_F,
        7'h00,
        ACT_STATES,
        6'h00
    };
    localparam logic [63:0] ENUM_VAL =
        {54'h0, MAX_INDEX, 1'b0};
    localparam logic [31:0] LIST_LIMIT =
        32'(VCR_LIST_UNIT * (int'(LIST_N) + 1));

    // ==========================================================
    // Register selection.
    logic [63:0] sel_val;
    logic        sel_hit;

    // Decodes the index to a constant; reads change no state.
    always_comb begin
        sel_hit = 1'b1;
        case (REG_INDEX)
            VCR_IDX_BASIC:     sel_val = BASIC_VAL;
            VCR_IDX_PIN_CTL:   sel_val = PIN_CAP;
            VCR_IDX_PROC_CTL:  sel_val = PROC_CAP;
            VCR_IDX_EXIT_CTL:  sel_val = EXIT_CAP;
            VCR_IDX_ENTRY_CTL: sel_val = ENTRY_CAP;
            VCR_IDX_MISC:      sel_val = MISC_VAL;
            VCR_IDX_CR0_F1S:   sel_val = CR0_FIX1S;
            VCR_IDX_CR0_F0S:   sel_val = CR0_FIX0S;
            VCR_IDX_CR4_F1S:   sel_val = CR4_FIX1S;
            VCR_IDX_CR4_F0S:   sel_val = CR4_FIX0S;
            VCR_IDX_ENUM:      sel_val = ENUM_VAL;
            default: begin
                sel_val = 64'h0;
                sel_hit = 1'b0;
            end
        endcase
    end

    // ==========================================================
    // Read and write port.
    logic [63:0] rd_data_reg;
    logic        rd_valid_reg;
    logic        gp_fault_reg;

    // Answers a read one cycle later; writes and misses fault.
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            rd_data_reg  <= 64'h0;
            rd_valid_reg <= 1'b0;
            gp_fault_reg <= 1'b0;
        end else begin
            rd_valid_reg <= RD_REQ && !WR_REQ && sel_hit;
            gp_fault_reg <= WR_REQ || (RD_REQ && !sel_hit);
            if (RD_REQ && !WR_REQ && sel_hit) begin
                rd_data_reg <= sel_val;
            end
        end
    end

    assign RD_DATA  = rd_data_reg;
    assign RD_VALID = rd_valid_reg;
    assign GP_FAULT = gp_fault_reg;
    assign GP_CODE  = VCR_GP_CODE;

    // ==========================================================
    // Structure memory type.
    logic [3:0] mtype_reg;

    // Uses uncacheable access while the range types are off.
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            mtype_reg <= VCR_MT_UC;
        end else if (!DEF_MEM_TYPE_REG[VCR_RANGE_TYPE_REGISTERS_E_BIT]) begin
            mtype_reg <= VCR_MT_UC;
        end else begin
            mtype_reg <= STRUCT_MTYPE;
        end
    end

    assign STRUCT_MEM_TYPE = mtype_reg;

    // ==========================================================
    // Entry checks.
    logic ctls_good;
    logic act_good;
    logic entry_done_reg;
    logic entry_fail_reg;
    logic list_over_reg;

    // All four control words must honour their capabilities.
    assign ctls_good = ctl_ok(PIN_CTLS, PIN_CAP)
                    && ctl_ok(PROC_CTLS, PROC_CAP)
                    && ctl_ok(EXIT_CTLS, EXIT_CAP)
                    && ctl_ok(ENTRY_CTLS, ENTRY_CAP);

    // Active is always allowed; others need their bitmap bit.
    // Bit 0 of the map stands for the active state, so no index
    // ever falls outside the map.
    localparam logic [3:0] ACT_MAP = {ACT_STATES, 1'b1};
    assign act_good = ACT_MAP[ACT_STATE];

    // Reports the verdict of each entry request one cycle later.
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            entry_done_reg <= 1'b0;
            entry_fail_reg <= 1'b0;
        end else begin
            entry_done_reg <= ENTRY_REQ;
            if (ENTRY_REQ) begin
                entry_fail_reg <= !(ctls_good && act_good);
            end
        end
    end

    // Flags a list beyond the recommended length at each request.
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            list_over_reg <= 1'b0;
        end else if (ENTRY_REQ) begin
            list_over_reg <= (EXIT_STORE_CNT > LIST_LIMIT)
                          || (EXIT_LOAD_CNT > LIST_LIMIT)
                          || (ENTRY_LOAD_CNT > LIST_LIMIT);
        end
    end

    assign ENTRY_DONE = entry_done_reg;
    assign ENTRY_FAIL = entry_fail_reg;
    assign LIST_OVER  = list_over_reg;

    // ==========================================================
    // Fixed bits of control registers zero and four.
    logic [63:0] creg0_reg;
    logic [63:0] creg4_reg;

    // Holds the fixed bits while operation is on.
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            creg0_reg <= 64'h0;
            creg4_reg <= 64'h0;
        end else if (VIRT_ON) begin
            creg0_reg <= fix_bits(CREG0_IN, CR0_FIX1S,
                                  CR0_FIX0S);
            creg4_reg <= fix_bits(CREG4_IN, CR4_FIX1S,
                                  CR4_FIX0S);
        end else begin
            creg0_reg <= CREG0_IN;
            creg4_reg <= CREG4_IN;
        end
    end

    assign CREG0_OUT = creg0_reg;
    assign CREG4_OUT = creg4_reg;

    // ==========================================================
    // Field encoding check.
    logic enc_ok_reg;

    // Reserved bits must be zero and the index within range.
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            enc_ok_reg <= 1'b0;
        end else begin
            enc_ok_reg <= (FIELD_ENC[31:VCR_ENC_RSV_LO] == 17'h0)
                && !FIELD_ENC[VCR_ENC_RSV12]
                && (FIELD_ENC[VCR_ENC_IDX_HI:VCR_ENC_IDX_LO]
                    <= MAX_INDEX);
        end
    end

    assign FIELD_ENC_OK = enc_ok_reg;

    // ==========================================================
    // Assertions.
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (RST);

    a_basic_read_value: assert property (
        (RD_REQ && !WR_REQ && REG_INDEX == VCR_IDX_BASIC)
        |=> (RD_VALID && RD_DATA[31:0] == STRUCT_REV
             && RD_DATA[49] && RD_DATA[47:45] == 3'h0))
        else $error("Basic register read wrong.");

    a_misc_reserved_zero: assert property (
        (RD_REQ && !WR_REQ && REG_INDEX == VCR_IDX_MISC)
        |=> (RD_DATA[5:0] == 6'h0 && RD_DATA[15:9] == 7'h0
             && RD_DATA[31:28] == 4'h0
             && RD_DATA[8:6] == ACT_STATES))
        else $error("Misc register read wrong.");

    a_write_faults: assert property (
        WR_REQ |=> (GP_FAULT && !RD_VALID && GP_CODE == 16'h0))
        else $error("Write did not fault.");

    a_read_stable: assert property (
        (!RD_REQ) |=> $stable(RD_DATA))
        else $error("Read data changed without a read.");

    a_uc_when_off: assert property (
        !DEF_MEM_TYPE_REG[VCR_RANGE_TYPE_REGISTERS_E_BIT]
        |=> STRUCT_MEM_TYPE == VCR_MT_UC)
        else $error("Type not uncacheable with ranges off.");

    a_pin_zero_fail: assert property (
        (ENTRY_REQ && |(~PIN_CTLS & PIN_CAP[31:0]))
        |=> (ENTRY_DONE && ENTRY_FAIL))
        else $error("Disallowed zero setting accepted.");

    a_entry_one_fail: assert property (
        (ENTRY_REQ && |(ENTRY_CTLS & ~ENTRY_CAP[63:32]))
        |=> ENTRY_FAIL)
        else $error("Disallowed one setting accepted.");

    a_active_state_ok: assert property (
        (ENTRY_REQ && ACT_STATE == VCR_ACT_ACTIVE && ctls_good)
        |=> !ENTRY_FAIL)
        else $error("Active state entry refused.");

    a_cr0_fixed_hold: assert property (
        VIRT_ON |=> ((CREG0_OUT & CR0_FIX1S) == CR0_FIX1S
                     && (CREG0_OUT & ~CR0_FIX0S) == 64'h0))
        else $error("Register zero fixed bits broken.");

    a_cr4_fixed_hold: assert property (
        VIRT_ON |=> ((CREG4_OUT & CR4_FIX1S) == CR4_FIX1S
                     && (CREG4_OUT & ~CR4_FIX0S) == 64'h0))
        else $error("Register four fixed bits broken.");

    a_enc_reserved_bad: assert property (
        (FIELD_ENC[VCR_ENC_RSV12] || FIELD_ENC[31])
        |=> !FIELD_ENC_OK)
        else $error("Encoding with reserved bits accepted.");

    a_list_limit_flag: assert property (
        (ENTRY_REQ && EXIT_STORE_CNT > LIST_LIMIT)
        |=> (ENTRY_DONE && LIST_OVER))
        else $error("List beyond limit not flagged.");

    a_enum_read_value: assert property (
        (RD_REQ && !WR_REQ && REG_INDEX == VCR_IDX_ENUM)
        |=> (RD_VALID && RD_DATA[63:10] == 54'h0
             && RD_DATA[9:1] == MAX_INDEX && !RD_DATA[0]))
        else $error("Enumeration register read wrong.");

endmodule

// ==== tb/vcr_bank_bench.sv ====
`timescale 1ns/1ps
module vcr_bank_bench;
    import vcr_pkg::*;
    // ==========================================================
    // Bench configuration, handed on to the design.
    localparam logic [31:0] S_REV   = 32'h0000_00A5;
    localparam int          R_SIZE  = 4096;
    localparam logic [63:0] P_CAP   = 64'h0000_001F_0000_0016;
    localparam logic [63:0] R_CAP   = 64'hFFFF_FFFF_0401_E172;
    localparam logic [63:0] X_CAP   = 64'h0003_6FFF_0003_6DFF;
    localparam logic [63:0] N_CAP   = 64'h0000_11FF_0000_11FF;
    localparam logic [2:0]  ACTS    = 3'h5;
    localparam int          CR3_CNT = 256;
    localparam logic [2:0]  L_N     = 3'h1;
    localparam logic [31:0] M_REV   = 32'h0000_0003;
    localparam logic [63:0] C0_1S   = 64'h0000_0000_8000_0021;
    localparam logic [63:0] C0_0S   = 64'h0000_0000_FFFF_FFFF;
    localparam logic [63:0] C4_1S   = 64'h0000_0000_0000_2000;
    localparam logic [63:0] C4_0S   = 64'h0000_0000_0000_27FF;
    localparam logic [8:0]  MAX_IX  = 9'h01C;
    localparam int          LIM     = 512 * (int'(L_N) + 1);
    typedef struct {
        logic [1:0]  kind;
        logic [63:0] val;
    } vcr_note_s;
    logic        CLK = 1'b0, RST = 1'b1, RD_REQ = 1'b0, WR_REQ = 1'b0;
    logic [11:0] REG_INDEX = 12'h000, DEF_MEM_TYPE_REG = 12'h000;
    logic        ENTRY_REQ = 1'b0, VIRT_ON = 1'b0, RD_VALID, GP_FAULT;
    logic [31:0] PIN_CTLS = 0, PROC_CTLS = 0, EXIT_CTLS = 0, ENTRY_CTLS = 0;
    logic [31:0] EXIT_STORE_CNT = 0, EXIT_LOAD_CNT = 0, ENTRY_LOAD_CNT = 0;
    logic [31:0] FIELD_ENC = 0, r, r2;
    integer      seed = 43;
    logic [1:0]  ACT_STATE = 2'h0;
    logic [63:0] CREG0_IN = 0, CREG4_IN = 0, RD_DATA, CREG0_OUT, CREG4_OUT;
    logic [15:0] GP_CODE;
    logic [3:0]  STRUCT_MEM_TYPE;
    logic        ENTRY_DONE, ENTRY_FAIL, LIST_OVER, FIELD_ENC_OK, raw;
    logic [63:0] regs [11];
    vcr_note_s   notes [$];
    vcr_note_s   note;
    int          n_errors = 0, checks_done = 0;

    vcr_bank #(.STRUCT_REV(S_REV), .REGION_SIZE(R_SIZE), .PIN_CAP(P_CAP),
        .PROC_CAP(R_CAP), .EXIT_CAP(X_CAP), .ENTRY_CAP(N_CAP),
        .ACT_STATES(ACTS), .CR3_COUNT(CR3_CNT), .LIST_N(L_N),
        .SEG_REV(M_REV), .CR0_FIX1S(C0_1S), .CR0_FIX0S(C0_0S),
        .CR4_FIX1S(C4_1S), .CR4_FIX0S(C4_0S), .MAX_INDEX(MAX_IX)) dut (
        .CLK(CLK), .RST(RST), .RD_REQ(RD_REQ), .WR_REQ(WR_REQ),
        .REG_INDEX(REG_INDEX), .RD_DATA(RD_DATA), .RD_VALID(RD_VALID),
        .GP_FAULT(GP_FAULT), .GP_CODE(GP_CODE),
        .DEF_MEM_TYPE_REG(DEF_MEM_TYPE_REG),
        .STRUCT_MEM_TYPE(STRUCT_MEM_TYPE), .ENTRY_REQ(ENTRY_REQ),
        .PIN_CTLS(PIN_CTLS), .PROC_CTLS(PROC_CTLS), .EXIT_CTLS(EXIT_CTLS),
        .ENTRY_CTLS(ENTRY_CTLS), .ACT_STATE(ACT_STATE),
        .EXIT_STORE_CNT(EXIT_STORE_CNT), .EXIT_LOAD_CNT(EXIT_LOAD_CNT),
        .ENTRY_LOAD_CNT(ENTRY_LOAD_CNT), .ENTRY_DONE(ENTRY_DONE),
        .ENTRY_FAIL(ENTRY_FAIL), .LIST_OVER(LIST_OVER), .VIRT_ON(VIRT_ON),
        .CREG0_IN(CREG0_IN), .CREG4_IN(CREG4_IN), .CREG0_OUT(CREG0_OUT),
        .CREG4_OUT(CREG4_OUT), .FIELD_ENC(FIELD_ENC),
        .FIELD_ENC_OK(FIELD_ENC_OK));

    // ==========================================================
    // Helpers.
    // The clock toggles every half period of 25 ns.
    always #25 CLK = ~CLK;

    task automatic check(input string name, input logic [63:0] seen,
                         input logic [63:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error %s: expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic test_done;
        $display("Checks done %0d, mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // A control word fails when a must-be-one bit is clear or a
    // must-be-zero bit is set.
    function automatic logic cfail(input logic [31:0] c,
                                   input logic [63:0] cap);
        return (|(~c & cap[31:0])) | (|(c & ~cap[63:32]));
    endfunction

    function automatic logic [31:0] pick(input logic [31:0] v,
                                         input logic [63:0] cap,
                                         input logic        rw);
        return rw ? v : ((v | cap[31:0]) & cap[63:32]);
    endfunction

    // Register request on the falling edge; the note goes in the queue.
    task automatic req(input logic rd, input logic wr, input logic [11:0] ix,
                       input logic [1:0] kind, input logic [63:0] v);
        @(negedge CLK);
        RD_REQ = rd;
        WR_REQ = wr;
        REG_INDEX = ix;
        notes.push_back('{kind, v});
    endtask

    task automatic entry(input logic [31:0] pc, input logic [31:0] rc,
                         input logic [31:0] xc, input logic [31:0] nc,
                         input logic [1:0] act, input logic [31:0] c0,
                         input logic [31:0] c1, input logic [31:0] c2);
        logic f;
        logic o;
        f = cfail(pc, P_CAP) | cfail(rc, R_CAP) | cfail(xc, X_CAP);
        f = f | cfail(nc, N_CAP) | (act != 2'h0 && !ACTS[act - 2'h1]);
        o = (c0 > LIM) || (c1 > LIM) || (c2 > LIM);
        @(negedge CLK);
        ENTRY_REQ = 1'b1;
        {PIN_CTLS, PROC_CTLS, EXIT_CTLS, ENTRY_CTLS} = {pc, rc, xc, nc};
        ACT_STATE = act;
        {EXIT_STORE_CNT, EXIT_LOAD_CNT, ENTRY_LOAD_CNT} = {c0, c1, c2};
        notes.push_back('{2'h2, {62'h0, o, f}});
    endtask

    task automatic idle;
        @(negedge CLK);
        RD_REQ = 1'b0;
        WR_REQ = 1'b0;
        ENTRY_REQ = 1'b0;
    endtask

    // ==========================================================
    // Monitor: each response takes the oldest note off the queue.
    always @(posedge CLK) begin
        #1;
        if (RD_VALID === 1'b1 || GP_FAULT === 1'b1
                || ENTRY_DONE === 1'b1) begin
            if (notes.size() == 0) begin
                check("unexpected response", 64'h1, 64'h0);
            end else begin
                note = notes.pop_front();
                case (note.kind)
                    2'h0: begin
                        check("read data", RD_DATA, note.val);
                        check("read fault", {63'h0, GP_FAULT}, 64'h0);
                    end
                    2'h1: begin
                        check("fault code", {48'h0, GP_CODE}, 64'h0);
                        check("held data", RD_DATA, note.val);
                        check("fault valid", {63'h0, RD_VALID}, 64'h0);
                    end
                    default: begin
                        check("entry verdict", {62'h0, LIST_OVER, ENTRY_FAIL},
                              note.val);
                    end
                endcase
            end
        end
    end

    // Watchdog: the tests need a few hundred cycles at most.
    initial begin
        repeat (3000) @(posedge CLK);
        n_errors++;
        $display("Error watchdog: expected finish seen hang");
        test_done();
    end

    // ==========================================================
    // Main sequence.
    initial begin
        regs[0] = {10'h000, VCR_MT_WB, 1'b1, 1'b0, 3'h0, 13'(R_SIZE), S_REV};
        regs[1] = P_CAP;
        regs[2] = R_CAP;
        regs[3] = X_CAP;
        regs[4] = N_CAP;
        regs[5] = {M_REV, 4'h0, L_N, 9'(CR3_CNT), 7'h00, ACTS, 6'h00};
        regs[6] = C0_1S;
        regs[7] = C0_0S;
        regs[8] = C4_1S;
        regs[9] = C4_0S;
        regs[10] = {54'h0, MAX_IX, 1'b0};
        repeat (2) @(posedge CLK);
        @(negedge CLK);
        RST = 1'b0;
        // Back-to-back reads of every register.
        for (int i = 0; i < 11; i++) begin
            req(1'b1, 1'b0, VCR_IDX_BASIC + 12'(i), 2'h0, regs[i]);
        end
        // Unmapped reads, then writes with a read raised too.
        req(1'b1, 1'b0, 12'h48B, 2'h1, regs[10]);
        req(1'b1, 1'b0, 12'h47F, 2'h1, regs[10]);
        for (int i = 0; i < 11; i++) begin
            req(1'b1, 1'b1, VCR_IDX_BASIC + 12'(i), 2'h1, regs[10]);
        end
        req(1'b1, 1'b0, VCR_IDX_MISC, 2'h0, regs[5]);
        idle();
        $display("Test register bank done");
        entry(pick(0, P_CAP, 0), pick(0, R_CAP, 0), pick(0, X_CAP, 0),
              pick(0, N_CAP, 0), 2'h0, LIM, LIM, LIM);
        for (int i = 0; i < 24; i++) begin
            r = $random(seed);
            r2 = $random(seed);
            raw = (i % 4 == 3);
            entry(pick(r, P_CAP, raw), pick(r2, R_CAP, raw),
                  pick(r ^ r2, X_CAP, raw), pick(~r, N_CAP, raw), r[1:0],
                  LIM - 1 + (r2 & 3), {22'h0, r2[9:0]},
                  {22'h0, r2[20:11]});
        end
        idle();
        $display("Test entry checks done");
        // A second reset in mid-run clears the held verdict and data.
        @(negedge CLK);
        RST = 1'b1;
        @(negedge CLK);
        check("rst verdict", {62'h0, LIST_OVER, ENTRY_FAIL}, 64'h0);
        check("rst data", RD_DATA, 64'h0);
        RST = 1'b0;
        for (int i = 0; i < 20; i++) begin
            @(negedge CLK);
            r = $random(seed);
            VIRT_ON = r[0];
            CREG0_IN = {$random(seed), $random(seed)};
            CREG4_IN = {$random(seed), $random(seed)};
            DEF_MEM_TYPE_REG = r[15:4];
            case (i % 4)
                0: FIELD_ENC = {17'h0, r[14:13], 1'b0, r[11:10], MAX_IX, r[0]};
                1: FIELD_ENC = {17'h0, r[14:13], 1'b0, r[11:10],
                                MAX_IX + 9'h1, r[0]};
                2: FIELD_ENC = r & 32'h0000_703F;
                default: FIELD_ENC = r;
            endcase
            @(posedge CLK);
            #1;
            check("creg0", CREG0_OUT, VIRT_ON ? (CREG0_IN | C0_1S) & C0_0S
                                              : CREG0_IN);
            check("creg4", CREG4_OUT, VIRT_ON ? (CREG4_IN | C4_1S) & C4_0S
                                              : CREG4_IN);
            check("mem type", {60'h0, STRUCT_MEM_TYPE},
                  DEF_MEM_TYPE_REG[11] ? {60'h0, VCR_MT_WB} : 64'h0);
            check("enc ok", {63'h0, FIELD_ENC_OK},
                  {63'h0, FIELD_ENC[31:15] == 0 && !FIELD_ENC[12]
                   && FIELD_ENC[9:1] <= MAX_IX});
        end
        $display("Test fixed bits and encodings done");
        repeat (3) @(posedge CLK);
        check("notes left", 64'(notes.size()), 64'h0);
        test_done();
    end
endmodule
